// File: common/tgdn_pkg.sv
`default_nettype none
package tgdn_pkg;
  localparam int CLK_NS      = 25;
  localparam int NODE_LAST   = 31;
  localparam int PAY_BYTES   = 4;
  localparam int GD_SLOTS    = 8;
  localparam int GD_FIRST    = 16;
  localparam int GD_LAST     = 23;

  // Times in ns
  localparam longint BYTE_STD_NS = 71500;
  localparam longint BYTE_768_NS = 143000;
  localparam longint BYTE_384_NS = 286000;
  localparam longint FIX_STD_NS  = 1090000;
  localparam longint FIX_EXT_NS  = 1160000;
  localparam longint FIX_768_NS  = 2330000;
  localparam longint FIX_384_NS  = 4660000;
  localparam longint IDLE_STD_NS = 26000;
  localparam longint IDLE_EXT_NS = 52000;
  localparam longint IDLE_768_NS = 104000;
  localparam longint IDLE_384_NS = 208000;
  localparam longint ROT_MIN_NS  = 3000000;
  localparam longint ROT_MAX_NS  = 400000000;

  typedef enum logic [1:0] {
    BAUD_STD, BAUD_EXT, BAUD_768, BAUD_384
  } tgdn_baud_t;
  typedef enum logic [1:0] {
    KIND_DATA, KIND_START, KIND_END, KIND_SIGNOFF
  } tgdn_kind_t;
  typedef logic [23:0]      tgdn_cyc_t;
  typedef logic [3:0][23:0] tgdn_cyc_tab_t;

  function automatic tgdn_cyc_t cyc_up(input longint t_ns);
    return tgdn_cyc_t'((t_ns + CLK_NS - 1) / CLK_NS);
  endfunction

  function automatic tgdn_cyc_t cyc_dn(input longint t_ns);
    return (t_ns < CLK_NS) ? 24'h00_0001 : tgdn_cyc_t'(t_ns / CLK_NS);
  endfunction

  // Senders that own a shared-data slot
  function automatic logic is_gd_src(input logic [4:0] n);
    return n[4:3] == 2'b10;
  endfunction

  localparam tgdn_cyc_t     ROT_MIN_CYC = cyc_up(ROT_MIN_NS);
  localparam tgdn_cyc_t     ROT_MAX_CYC = cyc_dn(ROT_MAX_NS);
  localparam tgdn_cyc_tab_t BYTE_CYC = {cyc_dn(BYTE_384_NS),
    cyc_dn(BYTE_768_NS), cyc_dn(BYTE_STD_NS), cyc_dn(BYTE_STD_NS)};
  localparam tgdn_cyc_tab_t FIX_CYC = {cyc_up(FIX_384_NS),
    cyc_up(FIX_768_NS), cyc_up(FIX_EXT_NS), cyc_up(FIX_STD_NS)};
  localparam tgdn_cyc_tab_t IDLE_CYC = {cyc_up(IDLE_384_NS),
    cyc_up(IDLE_768_NS), cyc_up(IDLE_EXT_NS), cyc_up(IDLE_STD_NS)};
  localparam logic [31:0]   RST_DATA = 32'h0000_0000;
endpackage
`default_nettype wire

// File: common/tgdn_bus_if.sv
`default_nettype none
interface tgdn_bus_if;
  logic                 n2p_valid;
  tgdn_pkg::tgdn_kind_t n2p_kind;
  logic [7:0]           n2p_data;
  logic                 p2n_valid;
  tgdn_pkg::tgdn_kind_t p2n_kind;
  logic [7:0]           p2n_data;

  modport node (
    output n2p_valid, n2p_kind, n2p_data,
    input  p2n_valid, p2n_kind, p2n_data
  );
  modport peer (
    input  n2p_valid, n2p_kind, n2p_data,
    output p2n_valid, p2n_kind, p2n_data
  );
endinterface
`default_nettype wire

// File: rtl/tgdn_turn_tracker.sv
`default_nettype none
module tgdn_turn_tracker (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            en,
  input  wire tgdn_pkg::tgdn_cyc_t idle_cyc,
  input  wire tgdn_pkg::tgdn_cyc_t rot_min,
  input  wire tgdn_pkg::tgdn_cyc_t rot_max,
  input  wire logic            activity,
  input  wire logic            signoff,
  output logic [4:0]           turn,
  output logic                 turn_start,
  output logic                 overrun
);
  import tgdn_pkg::*;

  logic      running, next_running;
  logic      busy, next_busy;
  logic      waiting, next_waiting;
  logic [4:0] next_turn;
  logic      next_turn_start, next_overrun;
  tgdn_cyc_t slot_cnt, next_slot_cnt;
  tgdn_cyc_t rot_cnt, next_rot_cnt;
  logic      adv;

  always_comb begin
    next_running    = running;
    next_busy       = busy;
    next_waiting    = waiting;
    next_turn       = turn;
    next_turn_start = 1'b0;
    next_overrun    = overrun;
    next_slot_cnt   = slot_cnt;
    next_rot_cnt    = rot_cnt;
    adv             = 1'b0;
    if (!en) begin
      next_running  = 1'b0;
      next_busy     = 1'b0;
      next_waiting  = 1'b0;
      next_turn     = 5'h00;
      next_slot_cnt = 24'h00_0000;
      next_rot_cnt  = 24'h00_0000;
    end else if (!running) begin
      next_running    = 1'b1;
      next_turn_start = 1'b1;
    end else begin
      if (rot_cnt != 24'hFF_FFFF)
        next_rot_cnt = rot_cnt + 24'h00_0001;
      if (rot_cnt >= rot_max)
        next_overrun = 1'b1;
      if (waiting) begin
        if (rot_cnt + 24'h00_0001 >= rot_min) begin
          next_waiting    = 1'b0;
          next_turn       = 5'h00;
          next_turn_start = 1'b1;
          next_rot_cnt    = 24'h00_0000;
        end
      end else begin
        next_slot_cnt = slot_cnt + 24'h00_0001;
        if (activity)
          next_busy = 1'b1;
        // Holder that has begun must sign off; silent slot is skipped
        adv = signoff || (!busy && !activity &&
          slot_cnt + 24'h00_0001 >= idle_cyc);
        if (adv) begin
          next_slot_cnt = 24'h00_0000;
          next_busy     = 1'b0;
          if (turn == 5'(NODE_LAST)) begin
            if (rot_cnt + 24'h00_0001 >= rot_min) begin
              next_turn       = 5'h00;
              next_turn_start = 1'b1;
              next_rot_cnt    = 24'h00_0000;
            end else begin
              next_waiting = 1'b1;
            end
          end else begin
            next_turn       = turn + 5'h01;
            next_turn_start = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      running    <= 1'b0;
      busy       <= 1'b0;
      waiting    <= 1'b0;
      turn       <= 5'h00;
      turn_start <= 1'b0;
      overrun    <= 1'b0;
      slot_cnt   <= 24'h00_0000;
      rot_cnt    <= 24'h00_0000;
    end else begin
      running    <= next_running;
      busy       <= next_busy;
      waiting    <= next_waiting;
      turn       <= next_turn;
      turn_start <= next_turn_start;
      overrun    <= next_overrun;
      slot_cnt   <= next_slot_cnt;
      rot_cnt    <= next_rot_cnt;
    end
  end
endmodule
`default_nettype wire

// File: rtl/tgdn_peer.sv
`default_nettype none
module tgdn_peer #(
  parameter tgdn_pkg::tgdn_cyc_tab_t BYTE_TAB = tgdn_pkg::BYTE_CYC,
  parameter tgdn_pkg::tgdn_cyc_tab_t FIX_TAB  = tgdn_pkg::FIX_CYC,
  parameter tgdn_pkg::tgdn_cyc_tab_t IDLE_TAB = tgdn_pkg::IDLE_CYC,
  parameter tgdn_pkg::tgdn_cyc_t     ROT_MIN  = tgdn_pkg::ROT_MIN_CYC,
  parameter tgdn_pkg::tgdn_cyc_t     ROT_MAX  = tgdn_pkg::ROT_MAX_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  tgdn_bus_if.peer                 bus,
  input  wire logic                en,
  input  wire logic [4:0]          node_num,
  input  wire tgdn_pkg::tgdn_baud_t baud,
  input  wire logic [31:0]         tx_data,
  output logic [31:0]              rx_data,
  output logic [4:0]               rx_src,
  output logic                     rx_stb,
  output logic                     overrun
);
  import tgdn_pkg::*;

  typedef enum {PS_IDLE, PS_SEND, PS_FIXED} tgdn_pst_t;
  tgdn_pst_t   st, next_st;
  tgdn_cyc_t   cnt, next_cnt;
  logic [2:0]  idx, next_idx;
  logic [31:0] shift, next_shift;
  logic        next_valid;
  tgdn_kind_t  next_kind;
  logic [7:0]  next_data;
  logic        rx_on, next_rx_on;
  logic [2:0]  rx_idx, next_rx_idx;
  logic [31:0] stage, next_stage;
  logic [31:0] next_rx_data;
  logic [4:0]  next_rx_src;
  logic        next_rx_stb;
  logic [4:0]  turn;
  logic        turn_start;

  tgdn_turn_tracker tgdn_turn_tracker_i (
    .clk        (clk),
    .rst        (rst),
    .en         (en),
    .idle_cyc   (IDLE_TAB[baud]),
    .rot_min    (ROT_MIN),
    .rot_max    (ROT_MAX),
    .activity   (bus.n2p_valid || bus.p2n_valid),
    .signoff    ((bus.n2p_valid && bus.n2p_kind == KIND_SIGNOFF) ||
                 (bus.p2n_valid && bus.p2n_kind == KIND_SIGNOFF)),
    .turn       (turn),
    .turn_start (turn_start),
    .overrun    (overrun)
  );

  always_comb begin
    next_st      = st;
    next_cnt     = cnt;
    next_idx     = idx;
    next_shift   = shift;
    next_valid   = 1'b0;
    next_kind    = KIND_DATA;
    next_data    = 8'h00;
    next_rx_on   = rx_on;
    next_rx_idx  = rx_idx;
    next_stage   = stage;
    next_rx_data = rx_data;
    next_rx_src  = rx_src;
    next_rx_stb  = 1'b0;
    case (st)
      PS_IDLE: if (en && turn_start && turn == node_num) begin
        next_shift = tx_data;
        next_valid = 1'b1;
        next_kind  = KIND_START;
        next_idx   = 3'd0;
        next_cnt   = BYTE_TAB[baud] - 24'h00_0001;
        next_st    = PS_SEND;
      end
      PS_SEND: if (cnt != 24'h00_0000) begin
        next_cnt = cnt - 24'h00_0001;
      end else if (idx < 3'(PAY_BYTES)) begin
        next_valid = 1'b1;
        next_data  = shift[7:0];
        next_shift = {8'h00, shift[31:8]};
        next_idx   = idx + 3'd1;
        next_cnt   = BYTE_TAB[baud] - 24'h00_0001;
      end else if (idx == 3'(PAY_BYTES)) begin
        next_valid = 1'b1;
        next_kind  = KIND_END;
        next_idx   = idx + 3'd1;
        next_cnt   = BYTE_TAB[baud] - 24'h00_0001;
      end else begin
        next_cnt = FIX_TAB[baud] - 24'h00_0001;
        next_st  = PS_FIXED;
      end
      PS_FIXED: if (cnt != 24'h00_0000) begin
        next_cnt = cnt - 24'h00_0001;
      end else begin
        next_valid = 1'b1;
        next_kind  = KIND_SIGNOFF;
        next_st    = PS_IDLE;
      end
      default: next_st = PS_IDLE;
    endcase
    if (bus.n2p_valid) begin
      case (bus.n2p_kind)
        KIND_START: begin
          next_rx_on  = 1'b1;
          next_rx_idx = 3'd0;
        end
        KIND_DATA: if (rx_on && rx_idx < 3'(PAY_BYTES)) begin
          next_stage  = {bus.n2p_data, stage[31:8]};
          next_rx_idx = rx_idx + 3'd1;
        end
        KIND_END: begin
          next_rx_on = 1'b0;
          if (rx_on && rx_idx == 3'(PAY_BYTES)) begin
            next_rx_data = stage;
            next_rx_src  = turn;
            next_rx_stb  = 1'b1;
          end
        end
        default: next_rx_on = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st            <= PS_IDLE;
      cnt           <= 24'h00_0000;
      idx           <= 3'd0;
      shift         <= RST_DATA;
      bus.p2n_valid <= 1'b0;
      bus.p2n_kind  <= KIND_DATA;
      bus.p2n_data  <= 8'h00;
      rx_on         <= 1'b0;
      rx_idx        <= 3'd0;
      stage         <= RST_DATA;
      rx_data       <= RST_DATA;
      rx_src        <= 5'h00;
      rx_stb        <= 1'b0;
    end else begin
      st            <= next_st;
      cnt           <= next_cnt;
      idx           <= next_idx;
      shift         <= next_shift;
      bus.p2n_valid <= next_valid;
      bus.p2n_kind  <= next_kind;
      bus.p2n_data  <= next_data;
      rx_on         <= next_rx_on;
      rx_idx        <= next_rx_idx;
      stage         <= next_stage;
      rx_data       <= next_rx_data;
      rx_src        <= next_rx_src;
      rx_stb        <= next_rx_stb;
    end
  end
endmodule
`default_nettype wire

// File: rtl/tgdn_node.sv
`default_nettype none
// Notes on behaviour
// - Turns rotate 0 to 31, then wrap
// - Absent node numbers skipped after short idle
// - Always listen; accept broadcast messages from senders 16 to 23 only
// - Send only in own turn; sign off
// - Full rotation never shorter than 3 ms
// - Full rotation never longer than 400 ms; a longer one only raises overrun
// - Fixed per-turn share depends on bit rate
// - Byte time depends on bit rate
// - Payload framed by start and end markers
// - Broadcast outgoing data every own turn
// - Buffer received data per sender for host
// - Hold latest host data until own turn
// - Newer received data overwrites unread copy
// - Host reads never disturb buffered data
// - Late host write waits for next turn
// - Only senders 16 to 23 fill slots
// - Host stopped means zero payload sent
module tgdn_node #(
  parameter tgdn_pkg::tgdn_cyc_tab_t BYTE_TAB = tgdn_pkg::BYTE_CYC,
  parameter tgdn_pkg::tgdn_cyc_tab_t FIX_TAB  = tgdn_pkg::FIX_CYC,
  parameter tgdn_pkg::tgdn_cyc_tab_t IDLE_TAB = tgdn_pkg::IDLE_CYC,
  parameter tgdn_pkg::tgdn_cyc_t     ROT_MIN  = tgdn_pkg::ROT_MIN_CYC,
  parameter tgdn_pkg::tgdn_cyc_t     ROT_MAX  = tgdn_pkg::ROT_MAX_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  tgdn_bus_if.node                 bus,
  input  wire logic                cfg_wr,
  input  wire logic [4:0]          cfg_node,
  input  wire tgdn_pkg::tgdn_baud_t cfg_baud,
  input  wire logic                host_run,
  input  wire logic                host_wr,
  input  wire logic [31:0]         host_wdata,
  input  wire logic [2:0]          host_rd_sel,
  output logic [31:0]              host_rdata,
  output logic                     configured,
  output logic                     overrun
);
  import tgdn_pkg::*;

  typedef enum {ST_IDLE, ST_SEND, ST_FIXED} tgdn_tst_t;

  tgdn_tst_t   st, next_st;
  tgdn_cyc_t   cnt, next_cnt;
  logic [2:0]  idx, next_idx;
  logic [31:0] tx_hold, next_tx_hold;
  logic [31:0] shift, next_shift;
  logic        next_valid;
  tgdn_kind_t  next_kind;
  logic [7:0]  next_data;
  logic [4:0]  my_node, next_my_node;
  tgdn_baud_t  baud, next_baud;
  logic        next_configured;
  logic        rx_on, next_rx_on;
  logic [2:0]  rx_idx, next_rx_idx;
  logic [31:0] stage, next_stage;
  logic [31:0] rx_buf [GD_SLOTS];
  logic [31:0] next_rx_buf [GD_SLOTS];
  logic [31:0] next_host_rdata;
  logic [4:0]  turn;
  logic        turn_start;

  // Own bytes count as bus traffic so all ends advance together
  tgdn_turn_tracker tgdn_turn_tracker_i (
    .clk        (clk),
    .rst        (rst),
    .en         (configured),
    .idle_cyc   (IDLE_TAB[baud]),
    .rot_min    (ROT_MIN),
    .rot_max    (ROT_MAX),
    .activity   (bus.n2p_valid || bus.p2n_valid),
    .signoff    ((bus.n2p_valid && bus.n2p_kind == KIND_SIGNOFF) ||
                 (bus.p2n_valid && bus.p2n_kind == KIND_SIGNOFF)),
    .turn       (turn),
    .turn_start (turn_start),
    .overrun    (overrun)
  );

  // Configuration and host side
  always_comb begin
    next_my_node    = my_node;
    next_baud       = baud;
    next_configured = configured;
    next_tx_hold    = tx_hold;
    if (cfg_wr) begin
      next_my_node    = cfg_node;
      next_baud       = cfg_baud;
      next_configured = 1'b1;
    end
    if (host_wr)
      next_tx_hold = host_wdata;
    next_host_rdata = rx_buf[host_rd_sel];
  end

  // Transmit sequencer
  always_comb begin
    next_st    = st;
    next_cnt   = cnt;
    next_idx   = idx;
    next_shift = shift;
    next_valid = 1'b0;
    next_kind  = KIND_DATA;
    next_data  = 8'h00;
    case (st)
      ST_IDLE: begin
        // Snapshot only at turn start; later writes wait a rotation
        if (configured && turn_start && turn == my_node) begin
          next_shift = host_run ? tx_hold : RST_DATA;
          next_valid = 1'b1;
          next_kind  = KIND_START;
          next_idx   = 3'd0;
          next_cnt   = BYTE_TAB[baud] - 24'h00_0001;
          next_st    = ST_SEND;
        end
      end
      ST_SEND: begin
        if (cnt != 24'h00_0000) begin
          next_cnt = cnt - 24'h00_0001;
        end else if (idx < 3'(PAY_BYTES)) begin
          next_valid = 1'b1;
          next_data  = shift[7:0];
          next_shift = {8'h00, shift[31:8]};
          next_idx   = idx + 3'd1;
          next_cnt   = BYTE_TAB[baud] - 24'h00_0001;
        end else if (idx == 3'(PAY_BYTES)) begin
          next_valid = 1'b1;
          next_kind  = KIND_END;
          next_idx   = idx + 3'd1;
          next_cnt   = BYTE_TAB[baud] - 24'h00_0001;
        end else begin
          next_cnt = FIX_TAB[baud] - 24'h00_0001;
          next_st  = ST_FIXED;
        end
      end
      ST_FIXED: begin
        if (cnt != 24'h00_0000) begin
          next_cnt = cnt - 24'h00_0001;
        end else begin
          next_valid = 1'b1;
          next_kind  = KIND_SIGNOFF;
          next_st    = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
  end

  // Receiver listens in every turn, own or not
  always_comb begin
    next_rx_on  = rx_on;
    next_rx_idx = rx_idx;
    next_stage  = stage;
    next_rx_buf = rx_buf;
    if (bus.p2n_valid) begin
      case (bus.p2n_kind)
        KIND_START: begin
          next_rx_on  = 1'b1;
          next_rx_idx = 3'd0;
          next_stage  = RST_DATA;
        end
        KIND_DATA: begin
          if (rx_on && rx_idx < 3'(PAY_BYTES)) begin
            next_stage  = {bus.p2n_data, stage[31:8]};
            next_rx_idx = rx_idx + 3'd1;
          end
        end
        KIND_END: begin
          next_rx_on = 1'b0;
          // Short or unframed blocks are dropped whole
          if (rx_on && rx_idx == 3'(PAY_BYTES) && is_gd_src(turn))
            next_rx_buf[turn[2:0]] = stage;
        end
        default: next_rx_on = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st            <= ST_IDLE;
      cnt           <= 24'h00_0000;
      idx           <= 3'd0;
      tx_hold       <= RST_DATA;
      shift         <= RST_DATA;
      bus.n2p_valid <= 1'b0;
      bus.n2p_kind  <= KIND_DATA;
      bus.n2p_data  <= 8'h00;
      my_node       <= 5'h00;
      baud          <= BAUD_STD;
      configured    <= 1'b0;
      rx_on         <= 1'b0;
      rx_idx        <= 3'd0;
      stage         <= RST_DATA;
      host_rdata    <= RST_DATA;
      for (int i = 0; i < GD_SLOTS; i++)
        rx_buf[i] <= RST_DATA;
    end else begin
      st            <= next_st;
      cnt           <= next_cnt;
      idx           <= next_idx;
      tx_hold       <= next_tx_hold;
      shift         <= next_shift;
      bus.n2p_valid <= next_valid;
      bus.n2p_kind  <= next_kind;
      bus.n2p_data  <= next_data;
      my_node       <= next_my_node;
      baud          <= next_baud;
      configured    <= next_configured;
      rx_on         <= next_rx_on;
      rx_idx        <= next_rx_idx;
      stage         <= next_stage;
      host_rdata    <= next_host_rdata;
      rx_buf        <= next_rx_buf;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tgdn_link_sva.sv
`default_nettype none
module tgdn_link_sva #(
  parameter int BYTE_C  = 4,
  parameter int FIX_C   = 20,
  parameter int ROT_MIN = 400,
  parameter int ROT_MAX = 5000
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 n2p_valid,
  input wire tgdn_pkg::tgdn_kind_t n2p_kind,
  input wire logic [7:0]           n2p_data,
  input wire logic                 p2n_valid,
  input wire tgdn_pkg::tgdn_kind_t p2n_kind,
  input wire logic [7:0]           p2n_data
);
  timeunit 1ns;
  timeprecision 100ps;
  import tgdn_pkg::*;
  localparam int BLK_GAP = 5 * BYTE_C;
  localparam int END_GAP = BYTE_C + FIX_C;

  logic        n_soff;
  logic [23:0] rot_cnt;
  logic [23:0] next_rot_cnt;
  logic        rot_seen;
  logic        next_rot_seen;

  assign n_soff = n2p_valid && n2p_kind == KIND_SIGNOFF;

  // Node sign-offs are one rotation apart: its turn length never varies
  always_comb begin
    next_rot_cnt  = n_soff ? 24'h00_0001 : rot_cnt + 24'h00_0001;
    next_rot_seen = rot_seen | n_soff;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rot_cnt  <= 24'h00_0000;
      rot_seen <= 1'b0;
    end else begin
      rot_cnt  <= next_rot_cnt;
      rot_seen <= next_rot_seen;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_start_then_data: assert property (
    n2p_valid && n2p_kind == KIND_START |->
      ##BYTE_C n2p_valid && n2p_kind == KIND_DATA)
    else $error("no data byte one byte time after start marker");
  chk_block_length: assert property (
    n2p_valid && n2p_kind == KIND_START |->
      ##BLK_GAP n2p_valid && n2p_kind == KIND_END)
    else $error("end marker not after four data bytes");
  chk_byte_spacing: assert property (
    n2p_valid && n2p_kind == KIND_DATA |->
      ##BYTE_C n2p_valid && n2p_kind inside {KIND_DATA, KIND_END})
    else $error("data byte spacing wrong");
  chk_fixed_share: assert property (
    n2p_valid && n2p_kind == KIND_END |->
      ##END_GAP n2p_valid && n2p_kind == KIND_SIGNOFF)
    else $error("sign-off not at end of fixed share");
  chk_quiet_after_end: assert property (
    n2p_valid && n2p_kind == KIND_END |-> ##1 !n2p_valid [*8])
    else $error("node sent during its fixed share");
  chk_one_talker: assert property (
    !(n2p_valid && p2n_valid))
    else $error("both ends sent in one cycle");
  chk_skip_not_zero: assert property (
    p2n_valid && p2n_kind == KIND_SIGNOFF |-> ##1 !n2p_valid [*5])
    else $error("node started inside a skipped turn");
  chk_rot_min: assert property (
    n_soff && rot_seen |-> rot_cnt >= ROT_MIN)
    else $error("rotation shorter than minimum");
  chk_rot_max: assert property (
    rot_seen |-> rot_cnt <= ROT_MAX)
    else $error("rotation longer than maximum");
  chk_marker_empty: assert property (
    n2p_valid && n2p_kind != KIND_DATA |-> n2p_data == 8'h00)
    else $error("node marker carried a data byte");
  chk_peer_marker: assert property (
    p2n_valid && p2n_kind != KIND_DATA |-> p2n_data == 8'h00)
    else $error("peer marker carried a data byte");
endmodule
`default_nettype wire

// File: testbench/token_bus_global_data_node_tb.sv
`default_nettype none
module token_bus_global_data_node_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tgdn_pkg::*;
  localparam int BYTE_N = 4;
  localparam int FIX_N  = 20;
  localparam int IDLE_N = 6;
  localparam int RMIN_N = 400;
  localparam int RMAX_N = 5000;
  localparam int WALK   = 6 * BYTE_N + FIX_N;
  localparam tgdn_cyc_tab_t BT = {4{24'(BYTE_N)}};
  localparam tgdn_cyc_tab_t FT = {4{24'(FIX_N)}};
  localparam tgdn_cyc_tab_t IT = {4{24'(IDLE_N)}};

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_wr = 1'b0;
  logic        host_run = 1'b1;
  logic        host_wr = 1'b0;
  logic        en = 1'b0;
  logic [4:0]  cfg_node = 5'h14;
  logic [4:0]  node_num = 5'h12;
  tgdn_baud_t  cfg_baud = BAUD_STD;
  tgdn_baud_t  baud = BAUD_STD;
  logic [31:0] host_wdata = 32'h0000_0000;
  logic [31:0] tx_data = 32'h0000_0000;
  logic [2:0]  host_rd_sel = 3'h0;
  logic [31:0] host_rdata;
  logic [31:0] rx_data;
  logic [4:0]  rx_src;
  logic        rx_stb;
  logic        configured;
  logic        overrun;
  logic        p_overrun;
  int          n_fail = 0;
  int          n_tests = 0;

  tgdn_bus_if tgdn_bus_if_i ();
  tgdn_node #(.BYTE_TAB(BT), .FIX_TAB(FT), .IDLE_TAB(IT),
    .ROT_MIN(24'(RMIN_N)), .ROT_MAX(24'(RMAX_N))) tgdn_node_i (
    .clk(clk), .rst(rst), .bus(tgdn_bus_if_i.node), .cfg_wr(cfg_wr),
    .cfg_node(cfg_node), .cfg_baud(cfg_baud), .host_run(host_run),
    .host_wr(host_wr), .host_wdata(host_wdata), .host_rd_sel(host_rd_sel),
    .host_rdata(host_rdata), .configured(configured), .overrun(overrun));
  tgdn_peer #(.BYTE_TAB(BT), .FIX_TAB(FT), .IDLE_TAB(IT),
    .ROT_MIN(24'(RMIN_N)), .ROT_MAX(24'(RMAX_N))) tgdn_peer_i (
    .clk(clk), .rst(rst), .bus(tgdn_bus_if_i.peer), .en(en),
    .node_num(node_num), .baud(baud), .tx_data(tx_data), .rx_data(rx_data),
    .rx_src(rx_src), .rx_stb(rx_stb), .overrun(p_overrun));
  tgdn_link_sva #(.BYTE_C(BYTE_N), .FIX_C(FIX_N), .ROT_MIN(RMIN_N),
    .ROT_MAX(RMAX_N)) tgdn_link_sva_i (
    .clk(clk), .rst(rst), .n2p_valid(tgdn_bus_if_i.n2p_valid),
    .n2p_kind(tgdn_bus_if_i.n2p_kind), .n2p_data(tgdn_bus_if_i.n2p_data),
    .p2n_valid(tgdn_bus_if_i.p2n_valid), .p2n_kind(tgdn_bus_if_i.p2n_kind),
    .p2n_data(tgdn_bus_if_i.p2n_data));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // 0: node start marker, 1: peer end marker, 2: peer took node block
  task automatic wait_ev(input int sel);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(negedge clk);
      if (sel == 0 && tgdn_bus_if_i.n2p_valid === 1'b1 &&
          tgdn_bus_if_i.n2p_kind === KIND_START) return;
      if (sel == 1 && tgdn_bus_if_i.p2n_valid === 1'b1 &&
          tgdn_bus_if_i.p2n_kind === KIND_END) return;
      if (sel == 2 && rx_stb === 1'b1 && rx_src === 5'h14) return;
    end
    n_fail++;
    $display("Error %0t: awaited bus event missing", $time);
  endtask

  task automatic read_slot(input int s, output logic [31:0] v);
    @(posedge clk);
    host_rd_sel <= 3'(s);
    repeat (2) @(negedge clk);
    v = host_rdata;
  endtask

  task automatic hwrite(input logic [31:0] d);
    @(posedge clk);
    host_wr    <= 1'b1;
    host_wdata <= d;
    @(posedge clk);
    host_wr    <= 1'b0;
  endtask

  // Peer enable follows the node's configured flag so trackers align
  task automatic start_up(input tgdn_baud_t b, input logic [4:0] pn);
    @(posedge clk);
    rst      <= 1'b1;
    en       <= 1'b0;
    baud     <= b;
    cfg_baud <= b;
    node_num <= pn;
    repeat (6) @(posedge clk);
    rst    <= 1'b0;
    @(posedge clk);
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    en     <= 1'b1;
  endtask

  task automatic test_reset;
    logic [31:0] v;
    int          s;
    int          talk;
    talk = 0;
    for (s = 0; s < 8; s++) begin
      read_slot(s, v);
      check(v, RST_DATA);
      if (tgdn_bus_if_i.n2p_valid !== 1'b0) talk++;
    end
    check(32'(configured), 32'h0000_0000);
    check(talk, 0);
    $display("test_reset done");
  endtask

  task automatic test_rx;
    logic [31:0] v;
    tx_data <= 32'hA5C3_0F81;
    wait_ev(1);
    wait_ev(1);
    read_slot(2, v);
    check(v, 32'hA5C3_0F81);
    read_slot(2, v);
    check(v, 32'hA5C3_0F81);
    read_slot(0, v);
    check(v, RST_DATA);
    $display("test_rx done");
  endtask

  task automatic test_tx;
    wait_ev(2);
    hwrite(32'h1234_5678);
    wait_ev(2);
    check(rx_data, 32'h1234_5678);
    wait_ev(2);
    check(rx_data, 32'h1234_5678);
    // Write inside the node's own turn must wait a rotation
    wait_ev(0);
    hwrite(32'h9E37_79B9);
    wait_ev(2);
    check(rx_data, 32'h1234_5678);
    wait_ev(2);
    check(rx_data, 32'h9E37_79B9);
    $display("test_tx done");
  endtask

  task automatic test_over;
    logic [31:0] v;
    @(posedge clk);
    tx_data <= 32'h0BAD_F00D;
    wait_ev(1);
    wait_ev(1);
    @(posedge clk);
    tx_data <= 32'h7E57_C0DE;
    wait_ev(1);
    read_slot(2, v);
    check(v, 32'h7E57_C0DE);
    $display("test_over done");
  endtask

  task automatic test_stop;
    wait_ev(2);
    @(posedge clk);
    host_run <= 1'b0;
    wait_ev(2);
    check(rx_data, 32'h0000_0000);
    @(posedge clk);
    host_run <= 1'b1;
    wait_ev(2);
    check(rx_data, 32'h9E37_79B9);
    check(32'({overrun, p_overrun}), 32'h0000_0000);
    $display("test_stop done");
  endtask

  task automatic test_foreign;
    logic [31:0] v;
    int          s;
    start_up(BAUD_STD, 5'h05);
    tx_data <= 32'hFACE_0001;
    wait_ev(1);
    wait_ev(1);
    for (s = 0; s < 8; s++) begin
      read_slot(s, v);
      check(v, RST_DATA);
    end
    wait_ev(2);
    check(rx_data, RST_DATA);
    $display("test_foreign done");
  endtask

  task automatic test_baud;
    int b;
    int k;
    for (b = 0; b < 4; b++) begin
      start_up(tgdn_baud_t'(b), 5'h12);
      wait_ev(0);
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (k < 200 && !(tgdn_bus_if_i.n2p_valid === 1'b1 &&
                 tgdn_bus_if_i.n2p_kind === KIND_SIGNOFF));
      check(k, WALK);
    end
    $display("test_baud done");
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    end_sim;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_reset;
    start_up(BAUD_STD, 5'h12);
    test_rx;
    test_tx;
    test_over;
    test_stop;
    test_foreign;
    test_baud;
    end_sim;
  end
endmodule
`default_nettype wire
